/* rtl/crc_converter.sv */
// Purpose: CR oscillation converter control with APB registers
// Assumes: Oscillator, pulse and time base clocks are asynchronous
// Notes: Edges are found by sampling at core_clk_in
// Notes on behaviour
// - Mode 0: reference plus sensors A and B
// - Mode 1: AC, sensor only via A start
// - Mode 2: capacitive, sensor via A start
// - External mode counts external pulses instead
// - Counted clock driven onto monitor output
// - Continuous run ignores every automatic stop
// - Up-counting writable measure counter, preloaded
// - Flags clear by writing one
// - Start refused while relevant flag set
// - Reference start bit reads one while running
// - Reference stops on either counter overflow
// - Measure overflow in reference sets done
// - Time base overflow in reference: error flag
// - Sensor start; time base counts down
// - Sensor stops on overflow or underflow
// - Measure overflow in sensor: error flag
// - Time base underflow sets sensor done
// - Counters step at core_clk_in on sampled edges
// - Per-flag enables gate one interrupt line
// - Converter disabled: start writes ignored
// - Sensor B start ignored in modes 1, 2
`timescale 1ns/1ps
module crc_converter #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Sensor network and clocks
  input wire logic oscillation_clock_in,
  input wire logic external_pulse_input_in,
  input wire logic timebase_clock_in,
  output logic ref_osc_enable_out,
  output logic sensor_a_osc_enable_out,
  output logic sensor_b_osc_enable_out,
  output logic [1:0] osc_mode_out,
  output logic oscillation_monitor_out,
  // Interrupt request to the interrupt controller
  output logic irq_out
);

  // Counters wider than the data bus cannot be served
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("crc_converter: CNT_W must be 2 to 32");
  end

  // Flag and mask fields must fit one 16-bit register
  if (crc_pkg::FLG_W < 1 || crc_pkg::FLG_W > 16) begin : g_bad_flags
    $error("crc_converter: FLG_W must be 1 to 16");
  end

  localparam logic [CNT_W-1:0] CNT_ONES = '1;
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    crc_pkg::crc_phase_e phase;
    logic enable;
    logic [1:0] mode;
    logic ext;
    logic cont;
    logic [CNT_W-1:0] mc;
    logic [CNT_W-1:0] tc;
    logic [crc_pkg::FLG_W-1:0] mask;
    logic [crc_pkg::FLG_W-1:0] flags;
    logic osc_s1;
    logic osc_s2;
    logic ext_s1;
    logic ext_s2;
    logic tb_s1;
    logic tb_s2;
    logic cnt_prev;
    logic tb_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic mon;
    logic ref_en;
    logic sena_en;
    logic senb_en;
  } crc_state_s;

  crc_state_s state_reg;
  crc_state_s state_next;

  // Byte address match for a register index
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
    hit = (addr == (idx << crc_pkg::ADDR_SHIFT));
  endfunction : hit

  // Zero-extend a counter to the data bus
  function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
    widen = 32'(v);
  endfunction : widen

  // Only the three defined modes accept a sensor start
  function automatic logic mode_legal(input logic [1:0] mode);
    mode_legal = (mode == crc_pkg::MODE_RDC) || (mode == crc_pkg::MODE_RAC) ||
                 (mode == crc_pkg::MODE_CDC);
  endfunction : mode_legal

  logic running;
  logic cnt_now;
  logic mc_edge;
  logic tb_edge;
  logic mc_ovf;
  logic tc_ovf;
  logic tc_unf;
  logic is_sensor;
  logic access;
  logic [crc_pkg::FLG_W-1:0] flag_set;
  logic [crc_pkg::FLG_W-1:0] flag_clr;
  logic [31:0] rd;
  logic mapped;
  logic ref_clear;
  logic sen_clear;

  // Whole next-state computation
  always_comb begin
    state_next = state_reg;
    flag_set = '0;
    flag_clr = '0;
    rd = 32'h0000_0000;
    mapped = 1'b0;

    // Two-flop synchronisers, first stage feeds only the second
    state_next.osc_s1 = oscillation_clock_in;
    state_next.osc_s2 = state_reg.osc_s1;
    state_next.ext_s1 = external_pulse_input_in;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.tb_s1 = timebase_clock_in;
    state_next.tb_s2 = state_reg.tb_s1;

    running = (state_reg.phase != crc_pkg::PH_IDLE);
    is_sensor = (state_reg.phase == crc_pkg::PH_SENA) ||
                (state_reg.phase == crc_pkg::PH_SENB);

    // Pick counted clock: own oscillation or external pulses
    cnt_now = state_reg.ext ? state_reg.ext_s2 : state_reg.osc_s2;
    state_next.tb_prev = state_reg.tb_s2;
    mc_edge = running && cnt_now && !state_reg.cnt_prev;
    tb_edge = running && state_reg.tb_s2 && !state_reg.tb_prev;

    // Measure counter counts up on each counted edge
    if (mc_edge) begin
      state_next.mc = state_reg.mc + CNT_ONE;
    end
    mc_ovf = mc_edge && (state_reg.mc == CNT_ONES);

    // Time base: up in reference, down in sensor phase
    if (tb_edge) begin
      if (is_sensor) begin
        state_next.tc = state_reg.tc - CNT_ONE;
      end else begin
        state_next.tc = state_reg.tc + CNT_ONE;
      end
    end
    tc_ovf = tb_edge && !is_sensor && (state_reg.tc == CNT_ONES);
    tc_unf = tb_edge && is_sensor && (state_reg.tc == CNT_ZERO);

    // Automatic stops, suppressed by continuous run
    if (!state_reg.cont) begin
      unique case (state_reg.phase)
        crc_pkg::PH_IDLE: begin
        end
        crc_pkg::PH_REF: begin
          // Time base overflow wins over a same-cycle measure overflow
          if (tc_ovf) begin
            flag_set[crc_pkg::FLG_OVTC] = 1'b1;
            state_next.phase = crc_pkg::PH_IDLE;
          end else if (mc_ovf) begin
            flag_set[crc_pkg::FLG_REF] = 1'b1;
            state_next.phase = crc_pkg::PH_IDLE;
          end
        end
        crc_pkg::PH_SENA, crc_pkg::PH_SENB: begin
          // Measure overflow wins over a same-cycle underflow
          if (mc_ovf) begin
            flag_set[crc_pkg::FLG_OVMC] = 1'b1;
            state_next.phase = crc_pkg::PH_IDLE;
          end else if (tc_unf) begin
            if (state_reg.phase == crc_pkg::PH_SENA) begin
              flag_set[crc_pkg::FLG_SENA] = 1'b1;
            end else begin
              flag_set[crc_pkg::FLG_SENB] = 1'b1;
            end
            state_next.phase = crc_pkg::PH_IDLE;
          end
        end
      endcase
    end

    // Relevant flags must be clear before a phase may start
    ref_clear = !state_reg.flags[crc_pkg::FLG_REF] &&
                !state_reg.flags[crc_pkg::FLG_OVTC];
    sen_clear = !state_reg.flags[crc_pkg::FLG_SENA] &&
                !state_reg.flags[crc_pkg::FLG_SENB] &&
                !state_reg.flags[crc_pkg::FLG_OVMC];

    // APB register writes, taken at the access edge
    access = psel_in && penable_in && state_reg.pready;
    if (access && pwrite_in) begin
      if (hit(paddr_in, crc_pkg::IDX_CTL)) begin
        state_next.enable = pwdata_in[crc_pkg::CTL_EN_BIT];
        state_next.mode = pwdata_in[crc_pkg::CTL_MODE_LO +: 2];
        state_next.ext = pwdata_in[crc_pkg::CTL_EXT_BIT];
        state_next.cont = pwdata_in[crc_pkg::CTL_CONT_BIT];
      end
      if (hit(paddr_in, crc_pkg::IDX_TRG) && state_reg.enable) begin
        // Idle: a start needs clear flags, a sensor start also a legal mode
        if (!running) begin
          if (pwdata_in[crc_pkg::TRG_REF_BIT]) begin
            if (ref_clear) begin
              state_next.phase = crc_pkg::PH_REF;
            end
          end else if (pwdata_in[crc_pkg::TRG_SENA_BIT]) begin
            if (sen_clear && mode_legal(state_reg.mode)) begin
              state_next.phase = crc_pkg::PH_SENA;
            end
          end else if (pwdata_in[crc_pkg::TRG_SENB_BIT]) begin
            if (sen_clear && state_reg.mode == crc_pkg::MODE_RDC) begin
              state_next.phase = crc_pkg::PH_SENB;
            end
          end
        end else begin
          // Writing zero to the running phase's bit stops it
          unique case (state_reg.phase)
            crc_pkg::PH_IDLE: begin
            end
            crc_pkg::PH_REF: begin
              if (!pwdata_in[crc_pkg::TRG_REF_BIT]) begin
                state_next.phase = crc_pkg::PH_IDLE;
              end
            end
            crc_pkg::PH_SENA: begin
              if (!pwdata_in[crc_pkg::TRG_SENA_BIT]) begin
                state_next.phase = crc_pkg::PH_IDLE;
              end
            end
            crc_pkg::PH_SENB: begin
              if (!pwdata_in[crc_pkg::TRG_SENB_BIT]) begin
                state_next.phase = crc_pkg::PH_IDLE;
              end
            end
          endcase
        end
      end
      // Counter writes override a same-cycle count
      if (hit(paddr_in, crc_pkg::IDX_MC)) begin
        state_next.mc = pwdata_in[CNT_W-1:0];
      end
      if (hit(paddr_in, crc_pkg::IDX_TC)) begin
        state_next.tc = pwdata_in[CNT_W-1:0];
      end
      if (hit(paddr_in, crc_pkg::IDX_MSK)) begin
        state_next.mask = pwdata_in[crc_pkg::FLG_W-1:0];
      end
      if (hit(paddr_in, crc_pkg::IDX_FLG)) begin
        flag_clr = pwdata_in[crc_pkg::FLG_W-1:0];
      end
    end

    // Write-one-to-clear, a same-cycle set wins
    state_next.flags = (state_reg.flags & ~flag_clr) | flag_set;

    // Read data prepared in the setup cycle
    if (hit(paddr_in, crc_pkg::IDX_CTL)) begin
      mapped = 1'b1;
      rd[crc_pkg::CTL_EN_BIT] = state_reg.enable;
      rd[crc_pkg::CTL_MODE_LO +: 2] = state_reg.mode;
      rd[crc_pkg::CTL_EXT_BIT] = state_reg.ext;
      rd[crc_pkg::CTL_CONT_BIT] = state_reg.cont;
    end
    if (hit(paddr_in, crc_pkg::IDX_TRG)) begin
      mapped = 1'b1;
      rd[crc_pkg::TRG_REF_BIT] = (state_reg.phase == crc_pkg::PH_REF);
      rd[crc_pkg::TRG_SENA_BIT] = (state_reg.phase == crc_pkg::PH_SENA);
      rd[crc_pkg::TRG_SENB_BIT] = (state_reg.phase == crc_pkg::PH_SENB);
    end
    if (hit(paddr_in, crc_pkg::IDX_MC)) begin
      mapped = 1'b1;
      rd = widen(state_reg.mc);
    end
    if (hit(paddr_in, crc_pkg::IDX_TC)) begin
      mapped = 1'b1;
      rd = widen(state_reg.tc);
    end
    if (hit(paddr_in, crc_pkg::IDX_MSK)) begin
      mapped = 1'b1;
      rd[crc_pkg::FLG_W-1:0] = state_reg.mask;
    end
    if (hit(paddr_in, crc_pkg::IDX_FLG)) begin
      mapped = 1'b1;
      rd[crc_pkg::FLG_W-1:0] = state_reg.flags;
    end

    // Zero-wait answer: ready in the first access cycle
    state_next.pready = psel_in && !penable_in;
    if (psel_in && !penable_in) begin
      state_next.prdata = pwrite_in ? 32'h0000_0000 : rd;
      state_next.pslverr = !mapped;
    end else begin
      state_next.prdata = 32'h0000_0000;
      state_next.pslverr = 1'b0;
    end

    // Single interrupt line, each source gated by its enable
    state_next.irq = |(state_reg.flags & state_reg.mask);

    // Oscillator network drive follows the next phase
    state_next.ref_en = (state_next.phase == crc_pkg::PH_REF) && !state_reg.ext;
    state_next.sena_en = (state_next.phase == crc_pkg::PH_SENA) && !state_reg.ext;
    state_next.senb_en = (state_next.phase == crc_pkg::PH_SENB) && !state_reg.ext;

    // Edge history follows the source of the next cycle, so a
    // source switch during a run cannot fake a counted edge
    state_next.cnt_prev = state_next.ext ? state_reg.ext_s2 : state_reg.osc_s2;

    // Monitor shows the clock being counted
    state_next.mon = running && cnt_now;
  end

  // State register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= '{
        phase: crc_pkg::PH_IDLE,
        enable: 1'b0,
        mode: crc_pkg::MODE_RST,
        ext: 1'b0,
        cont: 1'b0,
        mc: CNT_ZERO,
        tc: CNT_ZERO,
        mask: crc_pkg::MSK_RST,
        flags: crc_pkg::FLG_RST,
        prdata: 32'h0000_0000,
        default: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign prdata_out = state_reg.prdata;
  assign pready_out = state_reg.pready;
  assign pslverr_out = state_reg.pslverr;
  assign ref_osc_enable_out = state_reg.ref_en;
  assign sensor_a_osc_enable_out = state_reg.sena_en;
  assign sensor_b_osc_enable_out = state_reg.senb_en;
  assign osc_mode_out = state_reg.mode;
  assign oscillation_monitor_out = state_reg.mon;
  assign irq_out = state_reg.irq;

endmodule : crc_converter

/* rtl/crc_pkg.sv */
// Purpose: Shared constants for the CR oscillation converter
// Assumes: APB register access, one 32-bit word per register
// Notes: Byte address of a register is four times its index
package crc_pkg;
  // Register indices, byte address is index times four
  localparam logic [31:0] IDX_CTL = 32'h0000_53a0;
  localparam logic [31:0] IDX_TRG = 32'h0000_53a2;
  localparam logic [31:0] IDX_MC = 32'h0000_53a4;
  localparam logic [31:0] IDX_TC = 32'h0000_53a8;
  localparam logic [31:0] IDX_MSK = 32'h0000_53ac;
  localparam logic [31:0] IDX_FLG = 32'h0000_53ae;
  localparam int ADDR_SHIFT = 2;

  // Control register fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_EXT_BIT = 6;
  localparam int CTL_CONT_BIT = 7;

  // Start register fields
  localparam int TRG_REF_BIT = 0;
  localparam int TRG_SENA_BIT = 1;
  localparam int TRG_SENB_BIT = 2;

  // Flag and mask fields
  localparam int FLG_REF = 0;
  localparam int FLG_SENA = 1;
  localparam int FLG_SENB = 2;
  localparam int FLG_OVMC = 3;
  localparam int FLG_OVTC = 4;
  localparam int FLG_W = 5;

  // Oscillation modes
  localparam logic [1:0] MODE_RDC = 2'h0;
  localparam logic [1:0] MODE_RAC = 2'h1;
  localparam logic [1:0] MODE_CDC = 2'h2;

  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [4:0] FLG_RST = 5'h00;
  localparam logic [4:0] MSK_RST = 5'h00;

  // Conversion phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_REF,
    PH_SENA,
    PH_SENB
  } crc_phase_e;
endpackage : crc_pkg

/* verif/crc_converter_properties.sv */
// Purpose: Port-level checks of the CR oscillation converter
// Assumes: Bench keeps APB setup then access order
// Notes: Bound to every converter instance
`timescale 1ns/1ps
module crc_converter_properties #(
  parameter int CNT_W = 24
) (
  // Clock, reset and bus
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Converter side
  input wire logic ref_osc_enable_out,
  input wire logic sensor_a_osc_enable_out,
  input wire logic sensor_b_osc_enable_out,
  input wire logic [1:0] osc_mode_out,
  input wire logic oscillation_monitor_out,
  input wire logic irq_out
);
  logic wr_any;
  logic wr_trg;
  logic wr_ctl;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Completed writes seen on the bus
  assign wr_any = psel_in & penable_in & pready_out & pwrite_in;
  assign wr_trg = wr_any & (paddr_in == (crc_pkg::IDX_TRG << crc_pkg::ADDR_SHIFT));
  assign wr_ctl = wr_any & (paddr_in == (crc_pkg::IDX_CTL << crc_pkg::ADDR_SHIFT));
  AST_ONE_PHASE: assert property ($onehot0({ref_osc_enable_out, sensor_a_osc_enable_out,
    sensor_b_osc_enable_out})) else $error("two phases run at once");
  AST_NO_B_ALT: assert property (osc_mode_out != crc_pkg::MODE_RDC |->
    !sensor_b_osc_enable_out) else $error("sensor B runs outside mode 0");
  AST_START_CAUSE: assert property ($rose(|{ref_osc_enable_out, sensor_a_osc_enable_out,
    sensor_b_osc_enable_out}) |-> $past(wr_trg) || $past(wr_trg, 2) || $past(wr_trg, 3))
    else $error("phase began with no start write");
  AST_IRQ_CLR: assert property ($fell(irq_out) |->
    $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3)) else $error("irq fell unasked");
  AST_MODE_WR: assert property (!$stable(osc_mode_out) |->
    $past(wr_ctl) || $past(wr_ctl, 2) || $past(wr_ctl, 3)) else $error("mode moved alone");
  AST_READY_ACCESS: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out) else $error("ready too long");
  AST_ERR_READY: assert property (pslverr_out |-> pready_out) else $error("error w/o ready");
  AST_IDLE_DATA: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside access");
  AST_HIGH_ZERO: assert property (pready_out |-> prdata_out[31:24] == 8'h00)
    else $error("upper read bits set");
  // Main scenarios reached
  cover property ($rose(ref_osc_enable_out));
  cover property (irq_out);
  cover property (oscillation_monitor_out);
  cover property (pslverr_out);
endmodule : crc_converter_properties
bind crc_converter crc_converter_properties #(.CNT_W(CNT_W)) i_props (.*);

/* verif/crc_sensor_net.sv */
// Purpose: Behavioural RC sensor network for the converter
// Assumes: One element oscillates while its enable is high
// Notes: Clock stands low when no element is driven
`timescale 1ns/1ps
module crc_sensor_net (
  // Oscillator enables and speed choice
  input wire logic ref_en_in,
  input wire logic sena_en_in,
  input wire logic senb_en_in,
  input wire logic slow_in,
  // Oscillation clock
  output logic osc_clk_out
);
  initial osc_clk_out = 1'b0;
  // Toggle at a fast or slow rate, park low when idle
  always begin
    #(slow_in ? 100 : 60);
    osc_clk_out = (ref_en_in | sena_en_in | senb_en_in) ? ~osc_clk_out : 1'b0;
  end
endmodule : crc_sensor_net

/* verif/tb_top.sv */
// Purpose: Self-checking bench for the CR oscillation converter
// Assumes: Zero wait state APB slave
// Notes: Sensor model makes the oscillation clock
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic ext_pulse = 1'b0;
  logic tb_clk = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata, rdv, x;
  logic pready, pslverr, errv, osc_clk, ref_en, sena_en, senb_en, mon, irq;
  logic [1:0] mode;
  int mismatches = 0;
  int total_checks = 0;
  localparam logic [31:0] CTL = crc_pkg::IDX_CTL;
  localparam logic [31:0] TRG = crc_pkg::IDX_TRG;
  localparam logic [31:0] MC = crc_pkg::IDX_MC;
  localparam logic [31:0] TC = crc_pkg::IDX_TC;
  localparam logic [31:0] MSK = crc_pkg::IDX_MSK;
  localparam logic [31:0] FLG = crc_pkg::IDX_FLG;
  // Core clock and free running time base clock
  initial forever #10 core_clk_in = ~core_clk_in;
  initial forever #80 tb_clk = ~tb_clk;
  crc_converter i_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .oscillation_clock_in(osc_clk),
    .external_pulse_input_in(ext_pulse), .timebase_clock_in(tb_clk),
    .ref_osc_enable_out(ref_en), .sensor_a_osc_enable_out(sena_en),
    .sensor_b_osc_enable_out(senb_en), .osc_mode_out(mode),
    .oscillation_monitor_out(mon), .irq_out(irq));
  crc_sensor_net i_net (.ref_en_in(ref_en), .sena_en_in(sena_en), .senb_en_in(senb_en),
    .slow_in(slow), .osc_clk_out(osc_clk));
  // One APB transfer, held until ready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a << crc_pkg::ADDR_SHIFT;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rdv)
  endtask : rchk
  // Poll the start bits until no phase runs
  task automatic settle();
    for (int n = 0; n < 300; n++) begin
      bus(1'b0, TRG, 32'h0);
      if (rdv[2:0] === 3'h0) break;
    end
  endtask : settle
  // Load counters, clear flags, wait 20 core clocks, start
  task automatic start(input logic [31:0] m, input logic [31:0] t, input logic [31:0] go);
    bus(1'b1, MC, m);
    bus(1'b1, TC, t);
    bus(1'b1, FLG, 32'h1f);
    repeat (20) @(posedge core_clk_in);
    bus(1'b1, TRG, go);
  endtask : start
  task automatic phase(input logic [31:0] m, t, go, fl);
    start(m, t, go);
    rchk("running", TRG, go);
    `CHK("osc en", go[2:0], {senb_en, sena_en, ref_en})
    settle();
    rchk("flags", FLG, fl);
    rchk("stopped", TRG, 32'h0);
  endtask : phase
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hung wait
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
  // Test sequence
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rchk("ctl", CTL, {26'h0, crc_pkg::MODE_RST, 4'h0});
    rchk("msk", MSK, {27'h0, crc_pkg::MSK_RST});
    rchk("flg", FLG, {27'h0, crc_pkg::FLG_RST});
    bus(1'b0, 32'h100, 32'h0);
    `CHK("slverr", 1'b1, errv)
    bus(1'b1, TRG, 32'h1);
    rchk("off start", TRG, 32'h0);
    $display("test reset done");
    bus(1'b1, CTL, 32'h1);
    phase(32'h00fffffc, 32'h0, 32'h1, 32'h1);
    rchk("mc end", MC, 32'h0);
    bus(1'b0, TC, 32'h0);
    x = rdv;
    bus(1'b1, TRG, 32'h1);
    rchk("flag blocks", TRG, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, MSK, 32'h1);
    repeat (3) @(posedge core_clk_in);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, FLG, 32'h1);
    repeat (3) @(posedge core_clk_in);
    `CHK("irq clr", 1'b0, irq)
    $display("test reference done");
    phase(32'h0, x, 32'h2, 32'h2);
    phase(32'h0, x, 32'h4, 32'h4);
    phase(32'h00fffffe, 32'h1000, 32'h2, 32'h8);
    phase(32'h00ff0000, 32'h00fffffe, 32'h1, 32'h10);
    $display("test sensor done");
    for (int m = 1; m < 3; m++) begin
      bus(1'b1, CTL, 32'h1 | (m << 4));
      slow <= (m == 2);
      bus(1'b1, FLG, 32'h1f);
      `CHK("mode", m[1:0], mode)
      bus(1'b1, TRG, 32'h4);
      rchk("b refused", TRG, 32'h0);
      phase(32'h00fffffe, 32'h100, 32'h2, 32'h8);
    end
    $display("test modes done");
    bus(1'b1, CTL, 32'h41);
    start(32'h00fffffd, 32'h0, 32'h1);
    repeat (3) @(posedge core_clk_in);
    `CHK("ext osc", 1'b0, ref_en)
    for (int k = 0; k < 3; k++) begin
      repeat (3) @(posedge core_clk_in);
      ext_pulse <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      ext_pulse <= 1'b0;
      @(posedge core_clk_in);
      `CHK("monitor", 1'b1, mon)
    end
    settle();
    rchk("ext flg", FLG, 32'h1);
    `CHK("monitor idle", 1'b0, mon)
    $display("test external done");
    bus(1'b1, CTL, 32'h81);
    start(32'h00fffffe, 32'h0, 32'h1);
    repeat (100) @(posedge core_clk_in);
    rchk("cont run", TRG, 32'h1);
    rchk("cont flg", FLG, 32'h0);
    bus(1'b1, TRG, 32'h0);
    rchk("cont stop", TRG, 32'h0);
    $display("test continuous done");
    tally_and_finish();
  end
endmodule : tb_top
